// ### logic/aof_cfg.svh
`ifndef AOF_CFG_SVH
`define AOF_CFG_SVH
// ********************
// Register offsets
// ********************
`define AOF_OFS_GAIN_LO  7'h00
`define AOF_OFS_GAIN_HI  7'h01
`define AOF_OFS_MODE     7'h02
`define AOF_OFS_FINE     7'h03
`define AOF_OFS_OFFS_LO  7'h04
`define AOF_OFS_SYNC     7'h05
`define AOF_OFS_LVDS     7'h06
`define AOF_OFS_TEMP     7'h08
`define AOF_OFS_ID_FIRST 7'h17
`define AOF_OFS_ID_LAST  7'h1e
`define AOF_OFS_REV      7'h1f
// ********************
// Field positions
// ********************
`define AOF_BIT_DUAL 7
`define AOF_BIT_DIV4 6
`define AOF_BIT_OFS8 7
`define AOF_BIT_SYNC 0
`define AOF_BIT_TWOS 1
`define AOF_BIT_TEMP 2
`define AOF_TERM_LSB 0
`define AOF_DRV_LSB  2
`define AOF_BIT_SCR  4
`define AOF_PAT_LSB  5
// ********************
// Reset values and counts
// ********************
`define AOF_RST_GAIN   12'h800
`define AOF_RST_OFFSET 9'h100
`define AOF_RST_MODE   8'h00
`define AOF_RST_SYNC   8'h00
`define AOF_RST_LVDS   8'h00
`define AOF_PRBS_SEED  7'h7f
`define AOF_SPI_CMD    5'd8
`define AOF_SPI_FRAME  5'd16
`endif

// ### logic/aof_pkg.sv
package aof_pkg;
    typedef enum logic [1:0] {
        AOF_PAT_NONE   = 2'b00,
        AOF_PAT_TOGGLE = 2'b01,
        AOF_PAT_PRBS   = 2'b10,
        AOF_PAT_RSVD   = 2'b11
    } aof_pat_t;
    typedef enum logic [1:0] {
        AOF_TERM_NONE = 2'b00,
        AOF_TERM_100  = 2'b01,
        AOF_TERM_200  = 2'b10,
        AOF_TERM_OFF  = 2'b11
    } aof_term_t;
    typedef enum logic [1:0] {
        AOF_DRV_3P5 = 2'b00,
        AOF_DRV_2P5 = 2'b01,
        AOF_DRV_4P5 = 2'b10,
        AOF_DRV_5P5 = 2'b11
    } aof_drv_t;
    typedef enum logic [1:0] {
        AOF_SPI_IDLE = 2'b00,
        AOF_SPI_CMD  = 2'b01,
        AOF_SPI_DATA = 2'b10,
        AOF_SPI_DONE = 2'b11
    } aof_spi_t;
endpackage

// ### logic/aof_top.sv
// Operation
// - Forwarded clock comes from a divider of the input clock, half or quarter rate.
// - External reset pulse forces the divider to a known state and polarity.
// - Reset pin is captured high on the falling clock edge; early parts use rising.
// - Sync mode bit makes the range pin carry the sample marker instead.
// - Marker flags the sample present when the reset pin was captured high.
// - Marker appears on bus A in single-bus mode, bus B in dual-bus mode.
// - LVDS control selects 100 ohm, 200 ohm or no internal termination.
// - Driver current defaults to 3.5 mA, with 2.5, 4.5, 5.5 mA alternatives.
// - Range flag rises when the result falls below zero code or above full code.
// - Scramble mode XORs bits 11 to 1 with bit 0; bit 0 passes.
// - Toggle pattern drives all ones and all zeros on successive words.
// - In dual-bus mode toggle phase between buses is uncontrolled.
// - PRBS from seven-stage register, last two stages XORed into first.
// - PRBS generator is reloaded with its seed after every RST_B reset, not the reset pulse, and repeats its 127-bit period.
// - In PRBS mode all data outputs carry the same sequence bit.
// - Read-only 64-bit die identifier at die_ident_0..die_ident_7 and revision at die_revision.
// - Temperature sensor enable ignores global powerdown; reading at temperature_reading.
// - Offsets gain_adjust_a and gain_adjust_b hold a 12-bit gain code.
// - Offsets offset_fine_phase and offset_adjust_b hold a 9-bit offset code with trimmed default.
// - Offset bus_mode_coarse_phase holds coarse phase, offset_fine_phase holds fine phase.
// - Offset bus_mode_coarse_phase selects single-bus full rate or dual-bus alternating output.
// - Each bus carries twelve bits, highest bit most significant.
// - Offset sync_format_temp_ctrl selects two's complement or offset binary coding.
`timescale 1ns/1ps
`include "aof_cfg.svh"

module aof_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("aof_fifo: DEPTH must be a power of two, at least 2");
    end

    assign in_ready  = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
    assign out_valid = wr_ff != rd_ff;
    assign out_data  = mem[rd_ff[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= wr_ff + (AW + 1)'(push);
            rd_ff <= rd_ff + (AW + 1)'(pop);
        end
    end
endmodule // aof_fifo

module aof_top #(
    parameter bit          CAPTURE_RISE = 1'b0,
    parameter int          FIFO_DEPTH   = 8,
    parameter logic [63:0] DIE_ID       = 64'h0123_4567_89ab_cdef, // Arbitrary value
    parameter logic [7:0]  DIE_REV      = 8'h01,                   // Arbitrary value
    parameter logic [8:0]  OFFSET_TRIM  = `AOF_RST_OFFSET
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        RESET_PULSE,
    input  wire logic        SAMPLE_VALID,
    input  wire logic [13:0] RAW_CODE,
    output logic             SAMPLE_READY,
    input  wire logic        OUT_READY,
    output logic      [11:0] BUS_A_DATA,
    output logic      [11:0] BUS_B_DATA,
    output logic             RANGE_EXCEEDED_FLAG_A,
    output logic             RANGE_EXCEEDED_FLAG_B,
    output logic             FORWARDED_CLOCK_BUS_A,
    output logic             FORWARDED_CLOCK_BUS_B,
    input  wire logic        SPI_CS_B,
    input  wire logic        SPI_SCLK,
    input  wire logic        SPI_SDI,
    output logic             SPI_SDO,
    output logic             SPI_SDO_OE,
    output logic      [11:0] GAIN_CODE,
    output logic      [8:0]  OFFSET_CODE,
    output logic      [5:0]  COARSE_PHASE,
    output logic      [6:0]  FINE_PHASE,
    output logic             TERM_100_EN,
    output logic             TERM_200_EN,
    output logic      [1:0]  DRIVE_SEL,
    output logic             TEMP_SENSE_EN,
    input  wire logic [7:0]  TEMP_CODE,
    input  wire logic        POWERDOWN,
    output logic             CORE_PWR_EN
);
    // ********************
    // Pin synchronisers
    // ********************
    logic       rst_cap_ff, rst_sync_ff, rst_sync_d_ff, rst_rise;
    logic [2:0] spi_s1_ff, spi_s2_ff;
    logic       sclk_d_ff;
    logic [8:0] misc_s1_ff, misc_s2_ff;

    if (CAPTURE_RISE) begin : g_cap_rise
        always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) rst_cap_ff <= 1'b0;
            else rst_cap_ff <= RESET_PULSE;
        end
    end else begin : g_cap_fall
        always_ff @(negedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) rst_cap_ff <= 1'b0;
            else rst_cap_ff <= RESET_PULSE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_ff   <= 1'b0;
            rst_sync_d_ff <= 1'b0;
            spi_s1_ff     <= 3'h1;
            spi_s2_ff     <= 3'h1;
            sclk_d_ff     <= 1'b0;
            misc_s1_ff    <= 9'h000;
            misc_s2_ff    <= 9'h000;
        end else begin
            rst_sync_ff   <= rst_cap_ff;
            rst_sync_d_ff <= rst_sync_ff;
            spi_s1_ff     <= {SPI_SDI, SPI_SCLK, SPI_CS_B};
            spi_s2_ff     <= spi_s1_ff;
            sclk_d_ff     <= spi_s2_ff[1];
            misc_s1_ff    <= {POWERDOWN, TEMP_CODE};
            misc_s2_ff    <= misc_s1_ff;
        end
    end
    assign rst_rise = rst_sync_ff & ~rst_sync_d_ff;

    // ********************
    // Register file
    // ********************
    logic [7:0] gain_lo_ff, mode_ff, fine_ff, offs_lo_ff, sync_ff, lvds_ff;
    logic [3:0] gain_hi_ff;
    logic       wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic       dual, div4, sync_mode;
    aof_pkg::aof_pat_t pat;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            gain_lo_ff <= 8'(`AOF_RST_GAIN);
            gain_hi_ff <= 4'(`AOF_RST_GAIN >> 8);
            mode_ff    <= `AOF_RST_MODE;
            fine_ff    <= 8'h00;
            offs_lo_ff <= 8'h00;
            sync_ff    <= `AOF_RST_SYNC;
            lvds_ff    <= `AOF_RST_LVDS;
        end else if (wr_stb) begin
            case (wr_addr)
                `AOF_OFS_GAIN_LO: gain_lo_ff <= wr_data;
                `AOF_OFS_GAIN_HI: gain_hi_ff <= wr_data[3:0];
                `AOF_OFS_MODE:    mode_ff    <= wr_data;
                `AOF_OFS_FINE:    fine_ff    <= wr_data;
                `AOF_OFS_OFFS_LO: offs_lo_ff <= wr_data;
                `AOF_OFS_SYNC:    sync_ff    <= wr_data;
                `AOF_OFS_LVDS:    lvds_ff    <= wr_data;
                default: ;
            endcase
        end
    end

    // Offset code starts at the trimmed value; a write replaces it
    logic       offs_trim_ff;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) offs_trim_ff <= 1'b1;
        else if (wr_stb && (wr_addr == `AOF_OFS_FINE || wr_addr == `AOF_OFS_OFFS_LO)) offs_trim_ff <= 1'b0;
    end

    assign GAIN_CODE     = {gain_hi_ff, gain_lo_ff};
    assign OFFSET_CODE   = offs_trim_ff ? OFFSET_TRIM
                                        : {fine_ff[`AOF_BIT_OFS8], offs_lo_ff};
    assign COARSE_PHASE  = mode_ff[5:0];
    assign FINE_PHASE    = fine_ff[6:0];
    assign TERM_100_EN   = lvds_ff[`AOF_TERM_LSB+:2] == aof_pkg::AOF_TERM_100;
    assign TERM_200_EN   = lvds_ff[`AOF_TERM_LSB+:2] == aof_pkg::AOF_TERM_200;
    assign DRIVE_SEL     = lvds_ff[`AOF_DRV_LSB+:2];
    assign TEMP_SENSE_EN = sync_ff[`AOF_BIT_TEMP];
    assign CORE_PWR_EN   = ~misc_s2_ff[8];
    assign dual          = mode_ff[`AOF_BIT_DUAL];
    assign div4          = mode_ff[`AOF_BIT_DIV4] & dual;
    assign sync_mode     = sync_ff[`AOF_BIT_SYNC];
    assign pat           = aof_pkg::aof_pat_t'(lvds_ff[`AOF_PAT_LSB+:2]);

    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        logic [6:0] idx;
        idx = a - `AOF_OFS_ID_FIRST;
        case (a)
            `AOF_OFS_GAIN_LO: rd_mux = gain_lo_ff;
            `AOF_OFS_GAIN_HI: rd_mux = {4'h0, gain_hi_ff};
            `AOF_OFS_MODE:    rd_mux = mode_ff;
            `AOF_OFS_FINE:    rd_mux = {OFFSET_CODE[8], fine_ff[6:0]};
            `AOF_OFS_OFFS_LO: rd_mux = OFFSET_CODE[7:0];
            `AOF_OFS_SYNC:    rd_mux = sync_ff;
            `AOF_OFS_LVDS:    rd_mux = lvds_ff;
            `AOF_OFS_TEMP:    rd_mux = misc_s2_ff[7:0];
            `AOF_OFS_REV:     rd_mux = DIE_REV;
            default: begin
                if (a >= `AOF_OFS_ID_FIRST && a <= `AOF_OFS_ID_LAST) rd_mux = DIE_ID[{idx[2:0], 3'h0}+:8];
                else rd_mux = 8'h00;
            end
        endcase
    endfunction

    // ********************
    // Serial port slave
    // ********************
    aof_pkg::aof_spi_t spi_st_ff;
    logic [4:0]  bit_cnt_ff;
    logic [15:0] sh_in_ff;
    logic [7:0]  sh_out_ff;
    logic        cs_act, sclk_rise, sclk_fall, is_rd, rd_cmd_ff;

    assign cs_act    = ~spi_s2_ff[0];
    assign sclk_rise = spi_s2_ff[1] & ~sclk_d_ff;
    assign sclk_fall = ~spi_s2_ff[1] & sclk_d_ff;
    assign is_rd     = rd_cmd_ff;
    assign wr_addr   = sh_in_ff[14:8];
    assign wr_data   = sh_in_ff[7:0];
    assign wr_stb    = (spi_st_ff == aof_pkg::AOF_SPI_DONE) && (bit_cnt_ff == `AOF_SPI_FRAME) && !is_rd;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            spi_st_ff  <= aof_pkg::AOF_SPI_IDLE;
            bit_cnt_ff <= 5'd0;
            sh_in_ff   <= 16'h0000;
        end else if (!cs_act) begin
            spi_st_ff  <= aof_pkg::AOF_SPI_IDLE;
            bit_cnt_ff <= 5'd0;
        end else begin
            case (spi_st_ff)
                aof_pkg::AOF_SPI_IDLE: spi_st_ff <= aof_pkg::AOF_SPI_CMD;
                aof_pkg::AOF_SPI_CMD, aof_pkg::AOF_SPI_DATA: begin
                    if (sclk_rise) begin
                        sh_in_ff   <= {sh_in_ff[14:0], spi_s2_ff[2]};
                        bit_cnt_ff <= bit_cnt_ff + 5'd1;
                        if (bit_cnt_ff == `AOF_SPI_CMD - 5'd1) spi_st_ff <= aof_pkg::AOF_SPI_DATA;
                        if (bit_cnt_ff == `AOF_SPI_FRAME - 5'd1) spi_st_ff <= aof_pkg::AOF_SPI_DONE;
                    end
                end
                aof_pkg::AOF_SPI_DONE: bit_cnt_ff <= 5'd0;
                default: spi_st_ff <= aof_pkg::AOF_SPI_IDLE;
            endcase
        end
    end

    // Direction bit is kept for the whole frame to gate the data driver
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) rd_cmd_ff <= 1'b0;
        else if (spi_st_ff == aof_pkg::AOF_SPI_CMD && sclk_rise && bit_cnt_ff == 5'd0)
            rd_cmd_ff <= spi_s2_ff[2];
    end

    // Read data loads after the command byte and shifts out on falling edges
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) sh_out_ff <= 8'h00;
        else if (spi_st_ff == aof_pkg::AOF_SPI_CMD && sclk_rise && bit_cnt_ff == `AOF_SPI_CMD - 5'd1)
            sh_out_ff <= rd_mux({sh_in_ff[5:0], spi_s2_ff[2]}); // Last address bit arrives on this edge
        else if (spi_st_ff == aof_pkg::AOF_SPI_DATA && sclk_fall) sh_out_ff <= {sh_out_ff[6:0], 1'b0};
    end
    assign SPI_SDO    = sh_out_ff[7];
    assign SPI_SDO_OE = cs_act && spi_st_ff == aof_pkg::AOF_SPI_DATA && is_rd;

    // ********************
    // Sample formatting
    // ********************
    logic [11:0] clamp;
    logic        rng, mark_pend_ff, accept;
    logic [13:0] fifo_in, fifo_out;
    logic        fifo_ov, pop;

    always_comb begin
        rng   = RAW_CODE[13] || RAW_CODE[12];
        clamp = RAW_CODE[13] ? 12'h000 : (RAW_CODE[12] ? 12'hfff : RAW_CODE[11:0]);
        if (sync_ff[`AOF_BIT_TWOS]) clamp[11] = ~clamp[11];
    end
    assign accept  = SAMPLE_VALID & SAMPLE_READY;
    assign fifo_in = {rst_rise | mark_pend_ff, rng, clamp};

    // Marker waits for the next sample if none is present at capture
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) mark_pend_ff <= 1'b0;
        else if (rst_rise && !accept) mark_pend_ff <= 1'b1;
        else if (accept) mark_pend_ff <= 1'b0;
    end

    aof_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (SYS_CLK),
        .rst_b     (RST_B),
        .in_valid  (SAMPLE_VALID),
        .in_data   (fifo_in),
        .in_ready  (SAMPLE_READY),
        .out_valid (fifo_ov),
        .out_data  (fifo_out),
        .out_ready (OUT_READY)
    );
    assign pop = fifo_ov & OUT_READY;

    // ********************
    // Pattern generators
    // ********************
    logic [6:0] prbs_ff;
    logic       seeded_ff, tog_a_ff, tog_b_ff, sel_b_ff, ld_a, ld_b;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) seeded_ff <= 1'b0;
        else seeded_ff <= 1'b1;
    end
    // Advances on each pop, loaded with the seed after every RST_B reset (not the reset pulse) so it can never lock at zero
    always_ff @(posedge SYS_CLK) begin
        if (!seeded_ff) prbs_ff <= `AOF_PRBS_SEED;
        else if (pop) prbs_ff <= {prbs_ff[5:0], prbs_ff[6] ^ prbs_ff[5]};
    end

    assign ld_a = pop & (~dual | ~sel_b_ff);
    assign ld_b = pop & dual & sel_b_ff;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sel_b_ff <= 1'b0;
            tog_a_ff <= 1'b0;
            tog_b_ff <= 1'b0;
        end else begin
            sel_b_ff <= dual & (sel_b_ff ^ pop);
            tog_a_ff <= tog_a_ff ^ ld_a;
            tog_b_ff <= tog_b_ff ^ ld_b;
        end
    end

    function automatic logic [11:0] fmt(input logic [11:0] d, input logic tog);
        case (pat)
            aof_pkg::AOF_PAT_TOGGLE: fmt = {12{tog}};
            aof_pkg::AOF_PAT_PRBS:   fmt = {12{prbs_ff[6]}};
            default: fmt = lvds_ff[`AOF_BIT_SCR] ? {d[11:1] ^ {11{d[0]}}, d[0]} : d;
        endcase
    endfunction

    // ********************
    // Output buses
    // ********************
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BUS_A_DATA            <= 12'h000;
            BUS_B_DATA            <= 12'h000;
            RANGE_EXCEEDED_FLAG_A <= 1'b0;
            RANGE_EXCEEDED_FLAG_B <= 1'b0;
        end else begin
            if (ld_a) begin
                BUS_A_DATA            <= fmt(fifo_out[11:0], tog_a_ff);
                RANGE_EXCEEDED_FLAG_A <= sync_mode ? (~dual & fifo_out[13]) : fifo_out[12];
            end
            if (ld_b) begin
                BUS_B_DATA            <= fmt(fifo_out[11:0], tog_b_ff);
                RANGE_EXCEEDED_FLAG_B <= sync_mode ? fifo_out[13] : fifo_out[12];
            end
            if (!dual) RANGE_EXCEEDED_FLAG_B <= 1'b0;
        end
    end

    // ********************
    // Forwarded clock divider
    // ********************
    logic [1:0] div_ff, nxt_div;
    assign nxt_div = rst_sync_ff ? 2'b00 : div_ff + 2'b01;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_ff                <= 2'b00;
            FORWARDED_CLOCK_BUS_A <= 1'b0;
            FORWARDED_CLOCK_BUS_B <= 1'b0;
        end else begin
            div_ff                <= nxt_div;
            FORWARDED_CLOCK_BUS_A <= div4 ? nxt_div[1] : nxt_div[0];
            FORWARDED_CLOCK_BUS_B <= dual & (div4 ? nxt_div[1] : nxt_div[0]);
        end
    end

    // ********************
    // Checks
    // ********************
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    a_div_half_rate: assert property (seeded_ff && !div4 && !$past(div4) && !$past(div4, 2)
        && !rst_sync_ff && !$past(rst_sync_ff)
        |-> FORWARDED_CLOCK_BUS_A != $past(FORWARDED_CLOCK_BUS_A)) else $error("half rate clock stalled");
    a_div_known_state: assert property (rst_sync_ff |=> div_ff == 2'b00 && !FORWARDED_CLOCK_BUS_A)
        else $error("divider not forced by reset pulse");
    a_marker_pin_b: assert property (sync_mode && !dual && $past(!dual) |-> !RANGE_EXCEEDED_FLAG_B)
        else $error("marker on bus B in single mode");
    a_marker_tag_word: assert property (rst_rise && accept |-> fifo_in[13])
        else $error("captured sample not marked");
    a_range_clamp_low: assert property (accept && RAW_CODE[13] && !sync_ff[`AOF_BIT_TWOS]
        |-> fifo_in[12] && fifo_in[11:0] == 12'h000) else $error("under range not flagged");
    a_scramble_xor_bits: assert property (ld_a && pat == aof_pkg::AOF_PAT_NONE && lvds_ff[`AOF_BIT_SCR]
        |=> BUS_A_DATA == {$past(fifo_out[11:1]) ^ {11{$past(fifo_out[0])}}, $past(fifo_out[0])})
        else $error("scramble mismatch");
    a_toggle_words_alt: assert property (ld_a && pat == aof_pkg::AOF_PAT_TOGGLE ##1 ld_a
        && pat == aof_pkg::AOF_PAT_TOGGLE |=> BUS_A_DATA == ~$past(BUS_A_DATA)) else $error("toggle not alternating");
    a_prbs_taps_two: assert property (seeded_ff && pop ##1 pop
        |=> prbs_ff[0] == ($past(prbs_ff[5], 2) ^ $past(prbs_ff[4], 2))) else $error("prbs feedback wrong");
    a_prbs_all_same: assert property (ld_a && pat == aof_pkg::AOF_PAT_PRBS
        |=> BUS_A_DATA == {12{$past(prbs_ff[6])}}) else $error("prbs bits differ");

    c_dual_bus_pop: cover property (ld_a ##1 ld_b);
    c_fifo_full: cover property (!SAMPLE_READY);
    c_marker_out: cover property (sync_mode && RANGE_EXCEEDED_FLAG_A);
    c_reg_write: cover property (wr_stb && wr_addr == `AOF_OFS_LVDS);
endmodule // aof_top

// ### testbench/aof_rx_model.sv
`timescale 1ns/1ps
// ****************
// Receiver model
// ****************
module aof_rx_model (
    input  wire logic        stall,
    input  wire logic        scr_on,
    input  wire logic [11:0] bus_a,
    output logic             out_ready,
    output logic      [11:0] plain
);
    always_comb begin
        out_ready = !stall;
        plain     = scr_on ? {bus_a[11:1] ^ {11{bus_a[0]}}, bus_a[0]} : bus_a;
    end
endmodule // aof_rx_model

// ### testbench/tb_aof_top.sv
`timescale 1ns/1ps
module tb_aof_top;
    logic        clk, rst_b, pulse, valid, ready, ordy, fa, fb, ca, cb, cs_b, sclk, sdi, sdo, oe;
    logic        t100, t200, ten, pwr, pdn, stall, scr, a0;
    logic [13:0] raw;
    logic [11:0] bus_a, bus_b, gain, plain, a;
    logic [8:0]  offs;
    logic [6:0]  fine;
    logic [5:0]  coarse;
    logic [1:0]  drv;
    logic [7:0]  temp, rd;
    logic [9:0]  seq;
    int          n_fail, cmp_count;
    localparam logic [63:0] ID  = 64'hfeed_0042_1357_9bdf; // Arbitrary value
    localparam logic [7:0]  REV = 8'h3c;                   // Arbitrary value

    aof_top #(.DIE_ID(ID), .DIE_REV(REV)) DUT (.SYS_CLK(clk), .RST_B(rst_b), .RESET_PULSE(pulse),
        .SAMPLE_VALID(valid), .RAW_CODE(raw), .SAMPLE_READY(ready), .OUT_READY(ordy), .BUS_A_DATA(bus_a),
        .BUS_B_DATA(bus_b), .RANGE_EXCEEDED_FLAG_A(fa), .RANGE_EXCEEDED_FLAG_B(fb), .FORWARDED_CLOCK_BUS_A(ca),
        .FORWARDED_CLOCK_BUS_B(cb), .SPI_CS_B(cs_b), .SPI_SCLK(sclk), .SPI_SDI(sdi), .SPI_SDO(sdo),
        .SPI_SDO_OE(oe), .GAIN_CODE(gain), .OFFSET_CODE(offs), .COARSE_PHASE(coarse), .FINE_PHASE(fine),
        .TERM_100_EN(t100), .TERM_200_EN(t200), .DRIVE_SEL(drv), .TEMP_SENSE_EN(ten), .TEMP_CODE(temp),
        .POWERDOWN(pdn), .CORE_PWR_EN(pwr));
    aof_rx_model RX (.stall(stall), .scr_on(scr), .bus_a(bus_a), .out_ready(ordy), .plain(plain));

    // ****************
    // Tasks
    // ****************
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic spi(input logic rnw, input logic [6:0] ad, input logic [7:0] d);
        logic [15:0] f;
        f    = {rnw, ad, d};
        cs_b = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi  = f[i];
            sclk = 1'b0;
            step(6);
            sclk = 1'b1;
            step(6);
            if (i > 0 && i < 9) rd[i-1] = sdo;
            if (i == 4) chk("sdo_oe", rnw, oe);
        end
        sclk = 1'b0;
        step(6);
        cs_b = 1'b1;
        step(4);
    endtask
    task automatic push(input logic [13:0] c);
        int k;
        valid = 1'b1;
        raw   = c;
        for (k = 0; k < 40 && ready !== 1'b1; k++) step(1);
        if (k == 40) begin
            n_fail++;
            close_out();
        end
        step(1);
        valid = 1'b0;
    endtask
    task automatic send(input logic [13:0] c);
        push(c);
        step(4);
    endtask

    // ****************
    // Sequence
    // ****************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        n_fail = 0; cmp_count = 0; rst_b = 0; pulse = 0; valid = 0; raw = 0; stall = 0; scr = 0;
        cs_b = 1; sclk = 0; sdi = 0; temp = 8'h5a; pdn = 0;
        step(6);
        rst_b = 1'b1;
        step(3);
        chk("gain", 12'h800, gain);
        chk("offset", 9'h100, offs);
        chk("drive", 2'h0, drv);
        spi(0, 7'h00, 8'h34);
        spi(0, 7'h01, 8'h0a);
        chk("gain", 12'ha34, gain);
        spi(0, 7'h04, 8'h55);
        spi(0, 7'h03, 8'h91);
        chk("offset", 9'h155, offs);
        chk("fine", 7'h11, fine);
        spi(0, 7'h02, 8'h2a);
        chk("coarse", 6'h2a, coarse);
        for (int i = 0; i < 4; i++) begin
            spi(0, 7'h06, 8'(i * 5));
            chk("term100", 16'(i == 1), t100);
            chk("term200", 16'(i == 2), t200);
            chk("drive", 16'(i), drv);
        end
        spi(1, 7'h03, 8'h00);
        chk("rd03", 8'h91, rd);
        for (int i = 0; i < 8; i++) begin
            spi(1, 7'(8'h17 + i), 8'h00);
            chk("die_id", ID[i*8 +: 8], rd);
        end
        spi(0, 7'h1f, 8'h00);
        spi(1, 7'h1f, 8'h00);
        chk("die_rev", REV, rd);
        spi(1, 7'h7f, 8'h00);
        chk("unmapped", 8'h00, rd);
        spi(0, 7'h05, 8'h04);
        pdn = 1'b1;
        step(4);
        chk("temp_en", 1'b1, ten);
        chk("core_pwr", 1'b0, pwr);
        spi(1, 7'h08, 8'h00);
        chk("temp", 8'h5a, rd);
        pdn = 1'b0;
        spi(0, 7'h06, 8'h00);
        send(14'h123);
        chk("bus_a", 12'h123, bus_a);
        send(14'h1000);
        chk("over", 1'b1, fa);
        send(14'h3fff);
        chk("under", 1'b1, fa);
        send(14'h7ff);
        chk("in_range", 1'b0, fa);
        spi(0, 7'h05, 8'h02);
        send(14'h123);
        chk("twos", 12'h923, bus_a);
        spi(0, 7'h05, 8'h00);
        spi(0, 7'h06, 8'h10);
        scr = 1'b1;
        send(14'h123);
        chk("scramble", 12'hedd, bus_a);
        chk("descramble", 12'h123, plain);
        scr = 1'b0;
        spi(0, 7'h06, 8'h20);
        send(14'h123);
        a = bus_a;
        send(14'h123);
        chk("toggle", 12'(~a), bus_a);
        chk("toggle_full", 1'b1, a == 12'h000 || a == 12'hfff);
        stall = 1'b1;
        push(14'h123);
        step(1);
        push(14'h123);
        stall = 1'b0;
        step(4);
        chk("toggle_pair", 12'(~a), bus_a);
        spi(0, 7'h06, 8'h40);
        for (int n = 0; n < 10; n++) begin
            send(14'h123);
            seq[n] = bus_a[0];
            chk("prbs_all", {12{bus_a[0]}}, bus_a);
        end
        for (int n = 7; n < 10; n++) chk("prbs_seq", seq[n-6] ^ seq[n-7], seq[n]);
        spi(0, 7'h06, 8'h00);
        stall = 1'b1;
        for (int i = 1; i <= 8; i++) begin
            push(14'(i));
            step(1);
        end
        chk("full", 1'b0, ready);
        stall = 1'b0;
        step(12);
        chk("drained", 12'h008, bus_a);
        chk("ready", 1'b1, ready);
        spi(0, 7'h02, 8'h80);
        send(14'h0a1);
        send(14'h1000);
        chk("dual_a", 12'h0a1, bus_a);
        chk("dual_b", 12'hfff, bus_b);
        chk("range_b", 1'b1, fb);
        spi(0, 7'h02, 8'hc0);
        a0 = ca;
        step(2);
        chk("quarter_a", !a0, ca);
        chk("quarter_b", !a0, cb);
        spi(0, 7'h02, 8'h00);
        spi(0, 7'h05, 8'h01);
        pulse = 1'b1;
        step(5);
        chk("div_held", 1'b0, ca);
        step(1);
        chk("div_held", 1'b0, ca);
        send(14'h010);
        chk("marker", 1'b1, fa);
        pulse = 1'b0;
        send(14'h1000);
        chk("no_range", 1'b0, fa);
        a0 = ca;
        step(1);
        chk("half_rate", !a0, ca);
        close_out();
    end
endmodule // tb_aof_top
